// ===== charger_i2c_regs.sv
// i2c target, register file, watchdog, power mode control and interrupt pulse
// status inputs are assumed synchronous to i_mclk; i_scl is the link clock
module charger_i2c_regs #(
  parameter int unsigned SHIP_CYC  = charger_pkg::SHIP_CYC_DEF,
  parameter int unsigned PDOWN_CYC = charger_pkg::PDOWN_CYC_DEF,
  parameter int unsigned WDOG_CYC  = charger_pkg::WDOG_CYC_DEF
) (
  input  wire logic       i_mclk,
  input  wire logic       i_sys_rst,
  input  wire logic       i_scl,
  input  wire logic       i_sda_i,
  input  wire logic       i_trickle_timeout,
  input  wire logic       i_fast_charge_timeout,
  input  wire logic       i_battery_undervoltage,
  input  wire logic       i_sys_short,
  input  wire logic [1:0] i_charge_phase,
  input  wire logic       i_input_power_good,
  input  wire logic [2:0] i_temperature_zone,
  input  wire logic       i_over_temp,
  input  wire logic       i_battery_por,
  input  wire logic       i_one_wire_active,
  input  wire logic       i_one_wire_mode_wr,
  input  wire logic [1:0] i_one_wire_mode,
  output logic            o_scl_o,
  output logic            o_scl_oe_n,
  output logic            o_sda_o,
  output logic            o_sda_oe_n,
  output logic            o_irq_o,
  output logic            o_irq_oe_n,
  output logic [7:0]      o_power_path_control,
  output logic [7:0]      o_charge_voltage_term_control,
  output logic [7:0]      o_charge_enable_current_control,
  output logic [7:0]      o_watchdog_monitor_control,
  output logic            o_power_off,
  output logic            o_ship_mode,
  output logic            o_standby
);

  localparam int N_EV_W = charger_pkg::N_EV;

  // link domain
  charger_pkg::link_st_t lst_q;
  charger_pkg::ev_kind_t ev_kind_q;
  logic [3:0]            bit_q;
  logic [7:0]            shift_q;
  logic [7:0]            ev_byte_q;
  logic                  sda_pos_q;
  logic                  mack_q;
  logic                  ack_q;
  logic                  ev_tgl_q;

  // system domain
  charger_pkg::mode_st_t mst_q;
  logic [2:0]            ev_s_q;
  logic [7:0]            mask_q;
  logic [7:0]            ppc_q;
  logic [7:0]            cvt_q;
  logic [7:0]            cec_q;
  logic [7:0]            wdc_q;
  logic [7:0]            ptr_q;
  logic [7:0]            rd_byte_q;
  logic                  wdflag_q;
  logic [31:0]           wd_cnt_q;
  logic [31:0]           tmr_q;
  logic [11:0]           irq_cnt_q;
  logic                  standby_q;
  logic                  p_pg_q;
  logic                  p_short_q;
  logic                  p_tri_q;
  logic                  p_fast_q;
  logic                  p_uv_q;
  logic [1:0]            p_phase_q;
  logic [2:0]            p_tz_q;

  logic                  ev_fire;
  logic                  wr_hit;
  logic                  rd_hit;
  logic                  kick;
  logic                  wd_expire;
  logic                  load_def;
  logic                  defaults;
  logic                  rd_drive;
  logic [N_EV_W-1:0]     evs;
  logic                  irq_hit;
  logic [2:0]            tz_shown;

  // link state is reset without the clock: scl may stand still at reset
  always_ff @(posedge i_scl or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      sda_pos_q <= 1'b1;
      shift_q   <= 8'h00;
      mack_q    <= 1'b1;
    end
    else
    begin
      sda_pos_q <= i_sda_i;
      if (bit_q < charger_pkg::BIT_ACK)
        shift_q <= {shift_q[6:0], i_sda_i};
      else
        mack_q <= i_sda_i;
    end
  end

  // sda sampled high at the rising edge and low at the falling edge is a start
  always_ff @(negedge i_scl or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      lst_q     <= charger_pkg::L_IDLE;
      bit_q     <= 4'h0;
      ack_q     <= 1'b0;
      ev_tgl_q  <= 1'b0;
      ev_kind_q <= charger_pkg::EV_PTR;
      ev_byte_q <= 8'h00;
    end
    else if (sda_pos_q && !i_sda_i)
    begin
      lst_q <= charger_pkg::L_ADDR;
      bit_q <= 4'h0;
      ack_q <= 1'b0;
    end
    else if (lst_q != charger_pkg::L_IDLE)
    begin
      if (bit_q == charger_pkg::BIT_LAST)
      begin
        bit_q <= charger_pkg::BIT_ACK;
        ack_q <= (lst_q == charger_pkg::L_REG) ||
                 (lst_q == charger_pkg::L_WDATA) ||
                 ((lst_q == charger_pkg::L_ADDR) &&
                  (shift_q[7:1] == charger_pkg::DEV_ADDR));
      end
      else if (bit_q == charger_pkg::BIT_ACK)
      begin
        bit_q <= 4'h0;
        ack_q <= 1'b0;
        case (lst_q)
          charger_pkg::L_ADDR:
          begin
            if (!ack_q)
              lst_q <= charger_pkg::L_IDLE;
            else if (shift_q[0])
            begin
              lst_q     <= charger_pkg::L_RDATA;
              ev_tgl_q  <= ~ev_tgl_q;
              ev_kind_q <= charger_pkg::EV_RD;
            end
            else
              lst_q <= charger_pkg::L_REG;
          end
          charger_pkg::L_REG:
          begin
            lst_q     <= charger_pkg::L_WDATA;
            ev_tgl_q  <= ~ev_tgl_q;
            ev_kind_q <= charger_pkg::EV_PTR;
            ev_byte_q <= shift_q;
          end
          charger_pkg::L_WDATA:
          begin
            ev_tgl_q  <= ~ev_tgl_q;
            ev_kind_q <= charger_pkg::EV_WR;
            ev_byte_q <= shift_q;
          end
          charger_pkg::L_RDATA:
          begin
            if (!mack_q)
            begin
              ev_tgl_q  <= ~ev_tgl_q;
              ev_kind_q <= charger_pkg::EV_RD;
            end
            else
              lst_q <= charger_pkg::L_IDLE;
          end
          default:
            lst_q <= charger_pkg::L_IDLE;
        endcase
      end
      else
        bit_q <= bit_q + 4'h1;
    end
  end

  // read bits come from the byte the system side loaded while scl was held low
  always_comb
  begin
    rd_drive = (lst_q == charger_pkg::L_RDATA) && (bit_q < charger_pkg::BIT_ACK) &&
               !rd_byte_q[3'(charger_pkg::BIT_LAST - bit_q)];
  end

  assign o_sda_o    = 1'b0;
  assign o_sda_oe_n = ~(ack_q | rd_drive);
  assign o_scl_o    = 1'b0;
  // scl is held low from each byte event until the system side has served it
  assign o_scl_oe_n = ~(ev_tgl_q ^ ev_s_q[2]);

  // event toggle crossing; byte and kind stay still while scl is held
  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst)
      ev_s_q <= 3'h0;
    else
      ev_s_q <= {ev_s_q[1:0], ev_tgl_q};
  end

  assign ev_fire = ev_s_q[1] ^ ev_s_q[2];
  assign wr_hit  = ev_fire && (ev_kind_q == charger_pkg::EV_WR);
  assign rd_hit  = ev_fire && (ev_kind_q == charger_pkg::EV_RD);
  assign kick    = wr_hit && (ptr_q == charger_pkg::A_WDC) &&
                   ev_byte_q[charger_pkg::WDC_KICK];

  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst)
      ptr_q <= 8'h00;
    else if (ev_fire && (ev_kind_q == charger_pkg::EV_PTR))
      ptr_q <= ev_byte_q;
    else if (ev_fire)
      ptr_q <= ptr_q + 8'h01;
  end

  // zone reads as mid-range while the thermistor is switched off
  assign tz_shown = wdc_q[charger_pkg::WDC_NTC] ? i_temperature_zone :
                    charger_pkg::TZ_NTC_OFF;

  function automatic logic [7:0] reg_read(input logic [7:0] a);
    logic [7:0] v;
    v = 8'h00;
    case (a)
      charger_pkg::A_STAT0: v = {i_trickle_timeout, i_fast_charge_timeout, wdflag_q,
                                 i_battery_undervoltage, i_sys_short, i_charge_phase,
                                 i_input_power_good};
      charger_pkg::A_STAT1: v = {5'h00, tz_shown};
      charger_pkg::A_MASK:  v = mask_q;
      charger_pkg::A_PPC:   v = ppc_q;
      charger_pkg::A_CVT:   v = cvt_q;
      charger_pkg::A_CEC:   v = cec_q;
      charger_pkg::A_WDC:   v = wdc_q;
      default:              v = 8'h00;
    endcase
    return v;
  endfunction

  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst)
      rd_byte_q <= 8'h00;
    else if (rd_hit)
      rd_byte_q <= reg_read(ptr_q);
  end

  // register defaults: reset, battery por, the timed power-mode exits and the thermal exit once over-temp clears
  assign defaults = i_sys_rst || i_battery_por || load_def;

  always_ff @(posedge i_mclk)
  begin
    if (defaults)
    begin
      mask_q <= charger_pkg::RST_MASK;
      ppc_q  <= charger_pkg::RST_PPC;
      cvt_q  <= charger_pkg::RST_CVT;
      cec_q  <= charger_pkg::RST_CEC;
      wdc_q  <= charger_pkg::RST_WDC;
    end
    else
    begin
      if (wr_hit)
      begin
        case (ptr_q)
          charger_pkg::A_MASK: mask_q <= ev_byte_q & charger_pkg::WM_MASK;
          charger_pkg::A_PPC:  ppc_q  <= ev_byte_q & charger_pkg::WM_PPC;
          charger_pkg::A_CVT:  cvt_q  <= ev_byte_q;
          charger_pkg::A_CEC:  cec_q  <= ev_byte_q;
          // kick is a strobe only, so bit 7 always reads back zero
          charger_pkg::A_WDC:  wdc_q  <= ev_byte_q & charger_pkg::WM_WDC;
          default: ;
        endcase
      end
      if (i_one_wire_mode_wr)
        ppc_q[1:0] <= i_one_wire_mode;
    end
  end

  // watchdog counts on any supply; off, kicked or outside run it restarts
  always_ff @(posedge i_mclk)
  begin
    if (defaults || kick || !wdc_q[charger_pkg::WDC_EN] ||
        (mst_q != charger_pkg::M_RUN))
      wd_cnt_q <= 32'h0;
    else
      wd_cnt_q <= wd_cnt_q + 32'h1;
  end

  assign wd_expire = wdc_q[charger_pkg::WDC_EN] && (mst_q == charger_pkg::M_RUN) &&
                     (wd_cnt_q == WDOG_CYC - 32'h1);

  // flag survives the forced reset so software can see why; set beats clear
  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst || i_battery_por)
      wdflag_q <= 1'b0;
    else if (wd_expire)
      wdflag_q <= 1'b1;
    else if (rd_hit && (ptr_q == charger_pkg::A_STAT0))
      wdflag_q <= 1'b0;
  end

  always_comb
  begin
    load_def = 1'b0;
    case (mst_q)
      charger_pkg::M_PDOWN: load_def = (tmr_q == PDOWN_CYC - 32'h1);
      charger_pkg::M_SHIPW: load_def = (tmr_q == SHIP_CYC - 32'h1);
      charger_pkg::M_THERM: load_def = !i_over_temp;
      default:              load_def = 1'b0;
    endcase
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst)
    begin
      mst_q <= charger_pkg::M_RUN;
      tmr_q <= 32'h0;
    end
    else if (i_over_temp && (mst_q != charger_pkg::M_THERM))
      mst_q <= charger_pkg::M_THERM;
    else
    begin
      tmr_q <= tmr_q + 32'h1;
      case (mst_q)
        charger_pkg::M_RUN:
        begin
          tmr_q <= 32'h0;
          if (wd_expire || (ppc_q[1:0] == charger_pkg::MODE_PDOWN))
            mst_q <= charger_pkg::M_PDOWN;
          else if (ppc_q[1:0] == charger_pkg::MODE_SHIP)
            mst_q <= charger_pkg::M_SHIPW;
        end
        charger_pkg::M_PDOWN:
        begin
          if (load_def)
            mst_q <= charger_pkg::M_RUN;
        end
        charger_pkg::M_SHIPW:
        begin
          if (load_def)
            mst_q <= charger_pkg::M_SHIP;
        end
        charger_pkg::M_SHIP:
        begin
          if (i_input_power_good)
            mst_q <= charger_pkg::M_RUN;
        end
        charger_pkg::M_THERM:
        begin
          if (load_def)
            mst_q <= charger_pkg::M_RUN;
        end
        default:
          mst_q <= charger_pkg::M_RUN;
      endcase
    end
  end

  // standby is only a low-power hint; any wake source drops it next cycle
  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst)
      standby_q <= 1'b0;
    else
      standby_q <= (mst_q == charger_pkg::M_RUN) &&
                   (ppc_q[1:0] == charger_pkg::MODE_BYP) &&
                   !wdc_q[charger_pkg::WDC_EN] && !i_input_power_good &&
                   !i_one_wire_active && !i_battery_por;
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst)
    begin
      p_pg_q    <= 1'b0;
      p_short_q <= 1'b0;
      p_tri_q   <= 1'b0;
      p_fast_q  <= 1'b0;
      p_uv_q    <= 1'b0;
      p_phase_q <= 2'h0;
      p_tz_q    <= charger_pkg::TZ_NTC_OFF;
    end
    else
    begin
      p_pg_q    <= i_input_power_good;
      p_short_q <= i_sys_short;
      p_tri_q   <= i_trickle_timeout;
      p_fast_q  <= i_fast_charge_timeout;
      p_uv_q    <= i_battery_undervoltage;
      p_phase_q <= i_charge_phase;
      p_tz_q    <= tz_shown;
    end
  end

  always_comb
  begin
    evs = '0;
    evs[charger_pkg::MB_PG]    = i_input_power_good ^ p_pg_q;
    evs[charger_pkg::MB_SHORT] = i_sys_short && !p_short_q;
    evs[charger_pkg::MB_TMR]   = (i_trickle_timeout && !p_tri_q) ||
                                 (i_fast_charge_timeout && !p_fast_q) || wd_expire;
    evs[charger_pkg::MB_CHG]   = i_charge_phase != p_phase_q;
    evs[charger_pkg::MB_EOC]   = (i_charge_phase == charger_pkg::PHASE_EOC) &&
                                 (p_phase_q != charger_pkg::PHASE_EOC);
    evs[charger_pkg::MB_UV]    = i_battery_undervoltage && !p_uv_q;
    evs[charger_pkg::MB_TZ]    = tz_shown != p_tz_q;
  end

  assign irq_hit = |(evs & ~mask_q[N_EV_W-1:0]);

  // a new event restarts the pulse rather than queueing a second one
  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst)
      irq_cnt_q <= 12'h000;
    else if (irq_hit)
      irq_cnt_q <= charger_pkg::IRQ_CYC;
    else if (irq_cnt_q != 12'h000)
      irq_cnt_q <= irq_cnt_q - 12'h001;
  end

  assign o_irq_o    = 1'b0;
  assign o_irq_oe_n = (irq_cnt_q == 12'h000);

  assign o_power_path_control            = ppc_q;
  assign o_charge_voltage_term_control   = cvt_q;
  assign o_charge_enable_current_control = cec_q;
  assign o_watchdog_monitor_control      = wdc_q;
  assign o_power_off = (mst_q != charger_pkg::M_RUN);
  assign o_ship_mode = (mst_q == charger_pkg::M_SHIP);
  assign o_standby   = standby_q;

endmodule

// ===== charger_pkg.sv
// constants, types and layouts for the charger i2c target and control block
// assumes a 10 MHz system clock and a separate i2c link clock
package charger_pkg;

  localparam logic [6:0] DEV_ADDR = 7'h6B;

  localparam logic [7:0] A_STAT0 = 8'h00;
  localparam logic [7:0] A_STAT1 = 8'h01;
  localparam logic [7:0] A_MASK  = 8'h02;
  localparam logic [7:0] A_PPC   = 8'h03;
  localparam logic [7:0] A_CVT   = 8'h04;
  localparam logic [7:0] A_CEC   = 8'h05;
  localparam logic [7:0] A_WDC   = 8'h06;

  localparam logic [7:0] RST_MASK = 8'h00;
  localparam logic [7:0] RST_PPC  = 8'h3E;
  localparam logic [7:0] RST_CVT  = 8'hE4;
  localparam logic [7:0] RST_CEC  = 8'hF0;
  localparam logic [7:0] RST_WDC  = 8'h2B;

  localparam logic [7:0] WM_MASK = 8'h7F;
  localparam logic [7:0] WM_PPC  = 8'h3F;
  localparam logic [7:0] WM_WDC  = 8'h7F;

  localparam int WDC_KICK = 7;
  localparam int WDC_EN   = 6;
  localparam int WDC_NTC  = 5;
  localparam int MB_TZ    = 0;
  localparam int MB_TMR   = 1;
  localparam int MB_PG    = 2;
  localparam int MB_CHG   = 3;
  localparam int MB_SHORT = 4;
  localparam int MB_EOC   = 5;
  localparam int MB_UV    = 6;
  localparam int N_EV     = 7;

  localparam logic [1:0] MODE_PDOWN = 2'h1;
  localparam logic [1:0] MODE_SHIP  = 2'h3;
  localparam logic [1:0] MODE_BYP   = 2'h0;
  localparam logic [1:0] PHASE_EOC  = 2'h3;
  localparam logic [2:0] TZ_NTC_OFF = 3'h3;

  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_ACK  = 4'h8;

  localparam int CLK_HZ   = 10_000_000;
  localparam int IRQ_US   = 256;
  localparam int SHIP_S   = 1;
  localparam int PDOWN_S  = 8;
  localparam int WDOG_S   = 40;
  localparam logic [11:0] IRQ_CYC = 12'(IRQ_US * (CLK_HZ / 1_000_000));
  localparam int SHIP_CYC_DEF  = SHIP_S * CLK_HZ;
  localparam int PDOWN_CYC_DEF = PDOWN_S * CLK_HZ;
  localparam int WDOG_CYC_DEF  = WDOG_S * CLK_HZ;

  typedef enum logic [1:0] {EV_PTR, EV_WR, EV_RD} ev_kind_t;
  typedef enum logic [2:0] {L_IDLE, L_ADDR, L_REG, L_WDATA, L_RDATA} link_st_t;
  typedef enum logic [2:0] {M_RUN, M_PDOWN, M_SHIPW, M_SHIP, M_THERM} mode_st_t;

endpackage

// ===== charger_i2c_regs_checker.sv
// port assertions for the charger i2c target and power mode control
// bound to charger_i2c_regs by the bench; everything here is on i_mclk
module charger_i2c_regs_checker #(
  parameter int unsigned SHIP_CYC  = 50,
  parameter int unsigned PDOWN_CYC = 80,
  parameter int unsigned WDOG_CYC  = 200
) (
  input wire logic       i_mclk,
  input wire logic       i_sys_rst,
  input wire logic       i_input_power_good,
  input wire logic       i_over_temp,
  input wire logic       i_battery_por,
  input wire logic       i_one_wire_active,
  input wire logic       o_scl_o,
  input wire logic       o_sda_o,
  input wire logic       o_irq_o,
  input wire logic       o_scl_oe_n,
  input wire logic       o_irq_oe_n,
  input wire logic [7:0] o_power_path_control,
  input wire logic [7:0] o_charge_voltage_term_control,
  input wire logic [7:0] o_charge_enable_current_control,
  input wire logic [7:0] o_watchdog_monitor_control,
  input wire logic       o_power_off,
  input wire logic       o_ship_mode,
  input wire logic       o_standby
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_sys_rst);
  // 16 bits so that restarted pulses cannot wrap the count
  logic [15:0] irq_low_q;
  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst || o_irq_oe_n)
      irq_low_q <= 16'h0000;
    else
      irq_low_q <= irq_low_q + 16'h0001;
  end
  chk_irq_width: assert property ($rose(o_irq_oe_n) |->
    irq_low_q >= {4'h0, charger_pkg::IRQ_CYC})
    else $error("interrupt pulse too short");
  chk_open_drain: assert property (!o_scl_o && !o_sda_o && !o_irq_o)
    else $error("open drain pin driven high");
  chk_ship_exit: assert property (o_ship_mode && i_input_power_good |-> ##[1:4] !o_ship_mode)
    else $error("ship mode kept with supply present");
  chk_ship_hold: assert property (o_ship_mode && !i_input_power_good && !i_over_temp
    && !i_battery_por |=> o_ship_mode)
    else $error("ship mode left without supply");
  chk_therm_off: assert property (i_over_temp [*3] |-> o_power_off)
    else $error("power paths on while over temperature");
  chk_off_defaults: assert property ($fell(o_power_off) |->
    o_power_path_control == charger_pkg::RST_PPC
    && o_charge_voltage_term_control == charger_pkg::RST_CVT
    && o_charge_enable_current_control == charger_pkg::RST_CEC
    && o_watchdog_monitor_control == charger_pkg::RST_WDC)
    else $error("controls not at defaults after power off");
  chk_standby_exit: assert property (i_battery_por || i_input_power_good || i_one_wire_active
    |=> !o_standby)
    else $error("standby held while a wake condition stands");
  chk_stretch_len: assert property ($fell(o_scl_oe_n) |-> ##[1:6] o_scl_oe_n)
    else $error("clock stretch too long");
  chk_rsvd_zero: assert property (o_power_path_control[7:6] == 2'h0
    && !o_watchdog_monitor_control[7])
    else $error("reserved control bit set");
endmodule

// ===== charger_host_model.sv
// i2c controller model standing for the host side of the link
// open drain: the bench ands these releases with the device enables
module charger_host_model (
  input  wire logic i_scl_w,
  input  wire logic i_sda_w,
  output logic      o_scl_hi,
  output logic      o_sda_hi
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    o_scl_hi = 1'b1;
    o_sda_hi = 1'b1;
  end
  // 80 ns bit; waiting on the wire honours clock stretching, the bench bounds a hang
  task automatic bit_io(input logic b, output logic s);
    o_sda_hi = b;
    #20;
    o_scl_hi = 1'b1;
    wait (i_scl_w === 1'b1);
    #20;
    s = i_sda_w;
    #20;
    o_scl_hi = 1'b0;
    #20;
  endtask
  // scl goes low first: the target only sees a start after an scl rise with sda high
  task automatic start_cond();
    o_scl_hi = 1'b0;
    #20;
    o_sda_hi = 1'b1;
    #20;
    o_scl_hi = 1'b1;
    wait (i_scl_w === 1'b1);
    #20;
    o_sda_hi = 1'b0;
    #20;
    o_scl_hi = 1'b0;
    #20;
  endtask
  task automatic stop_cond();
    o_sda_hi = 1'b0;
    #20;
    o_scl_hi = 1'b1;
    wait (i_scl_w === 1'b1);
    #20;
    o_sda_hi = 1'b1;
    #60;
  endtask
  task automatic xfer(input logic [7:0] tx, input logic mack, output logic [7:0] rx,
                      output logic ack);
    for (int i = 7; i >= 0; i--)
      bit_io(tx[i], rx[i]);
    bit_io(mack, ack);
  endtask
endmodule

// ===== charger_i2c_regs_tb.sv
// self-checking bench: register access over i2c, interrupt pulse and power modes
// link driven by charger_host_model; status inputs driven on i_mclk
module charger_i2c_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned SHIP_CYC  = 50;
  localparam int unsigned PDOWN_CYC = 80;
  localparam int unsigned WDOG_CYC  = 200;
  localparam logic [7:0] WMSK [5] = '{charger_pkg::WM_MASK, charger_pkg::WM_PPC, 8'hFF, 8'hFF,
    charger_pkg::WM_WDC};
  localparam logic [7:0] RSTV [8] = '{8'h00, 8'h04, charger_pkg::RST_MASK, charger_pkg::RST_PPC,
    charger_pkg::RST_CVT, charger_pkg::RST_CEC, charger_pkg::RST_WDC, 8'h00};
  logic       i_mclk = 1'b0;
  logic       i_sys_rst = 1'b1;
  logic       i_trickle_timeout = 1'b1;
  logic       i_fast_charge_timeout = 1'b0;
  logic       i_battery_undervoltage = 1'b1;
  logic       i_sys_short = 1'b0;
  logic [1:0] i_charge_phase = 2'h2;
  logic       i_input_power_good = 1'b1;
  logic [2:0] i_temperature_zone = 3'h4;
  logic       i_over_temp = 1'b0;
  logic       i_battery_por = 1'b0;
  logic       i_one_wire_active = 1'b0;
  logic       i_one_wire_mode_wr = 1'b0;
  logic [1:0] i_one_wire_mode = 2'h0;
  logic       scl_hi, sda_hi, i_scl, i_sda_i, ack;
  logic       o_scl_o, o_scl_oe_n, o_sda_o, o_sda_oe_n, o_irq_o, o_irq_oe_n;
  logic       o_power_off, o_ship_mode, o_standby;
  logic [7:0] o_power_path_control, o_charge_voltage_term_control;
  logic [7:0] o_charge_enable_current_control, o_watchdog_monitor_control, rx;
  logic [7:0] wbuf [8];
  logic [7:0] rbuf [8];
  int         errors = 0;
  int         tests_run = 0;
  assign i_scl = scl_hi & (o_scl_oe_n | o_scl_o);
  assign i_sda_i = sda_hi & (o_sda_oe_n | o_sda_o);
  always #50 i_mclk = ~i_mclk;
  charger_host_model u_host (.i_scl_w(i_scl), .i_sda_w(i_sda_i), .o_scl_hi(scl_hi),
    .o_sda_hi(sda_hi));
  charger_i2c_regs #(.SHIP_CYC(SHIP_CYC), .PDOWN_CYC(PDOWN_CYC), .WDOG_CYC(WDOG_CYC)) dut (
    .i_mclk, .i_sys_rst, .i_scl, .i_sda_i, .i_trickle_timeout, .i_fast_charge_timeout,
    .i_battery_undervoltage, .i_sys_short, .i_charge_phase, .i_input_power_good,
    .i_temperature_zone, .i_over_temp, .i_battery_por, .i_one_wire_active, .i_one_wire_mode_wr,
    .i_one_wire_mode, .o_scl_o, .o_scl_oe_n, .o_sda_o, .o_sda_oe_n, .o_irq_o, .o_irq_oe_n,
    .o_power_path_control, .o_charge_voltage_term_control, .o_charge_enable_current_control,
    .o_watchdog_monitor_control, .o_power_off, .o_ship_mode, .o_standby);
  task automatic complete_run();
    if (errors == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_mclk);
  endtask
  function automatic logic [7:0] stat0(input logic wd);
    return {i_trickle_timeout, i_fast_charge_timeout, wd, i_battery_undervoltage, i_sys_short,
      i_charge_phase, i_input_power_good};
  endfunction
  task automatic addr_phase(input logic [7:0] a);
    u_host.start_cond();
    u_host.xfer({charger_pkg::DEV_ADDR, 1'b0}, 1'b1, rx, ack);
    check(ack, 1'b0);
    u_host.xfer(a, 1'b1, rx, ack);
    check(ack, 1'b0);
  endtask
  task automatic wr_n(input logic [7:0] a, input int n);
    addr_phase(a);
    for (int i = 0; i < n; i++)
    begin
      u_host.xfer(wbuf[i], 1'b1, rx, ack);
      check(ack, 1'b0);
    end
    u_host.stop_cond();
  endtask
  task automatic wr1(input logic [7:0] a, input logic [7:0] d);
    wbuf[0] = d;
    wr_n(a, 1);
  endtask
  task automatic rd_n(input logic [7:0] a, input int n);
    addr_phase(a);
    u_host.start_cond();
    u_host.xfer({charger_pkg::DEV_ADDR, 1'b1}, 1'b1, rx, ack);
    check(ack, 1'b0);
    for (int i = 0; i < n; i++)
      u_host.xfer(8'hFF, i == n - 1, rbuf[i], ack);
    u_host.stop_cond();
  endtask
  initial
  begin
    repeat (60000) @(posedge i_mclk);
    errors++;
    complete_run();
  end
  initial
  begin
    cyc(12);
    i_sys_rst <= 1'b0;
    cyc(4);
    rd_n(8'h00, 8);
    for (int i = 0; i < 8; i++)
      check(rbuf[i], (i == 0) ? stat0(1'b0) : RSTV[i]);
    check(o_charge_enable_current_control, charger_pkg::RST_CEC);
    wbuf = '{8'hFF, 8'hF6, 8'h5A, 8'hA5, 8'hBF, 8'h00, 8'h00, 8'h00};
    wr_n(8'h02, 5);
    rd_n(8'h02, 5);
    for (int i = 0; i < 5; i++)
      check(rbuf[i], wbuf[i] & WMSK[i]);
    check(o_power_path_control, 8'h36);
    wr_n(8'h00, 2);
    rd_n(8'h00, 2);
    check(rbuf[0], stat0(1'b0));
    check(rbuf[1], 8'h04);
    wr1(8'h06, 8'h1F);
    rd_n(8'h01, 1);
    check(rbuf[0], {5'h00, charger_pkg::TZ_NTC_OFF});
    wr1(8'h06, charger_pkg::RST_WDC);
    u_host.start_cond();
    u_host.xfer(8'h54, 1'b1, rx, ack);
    u_host.stop_cond();
    check(ack, 1'b1);
    cyc(2600);
    wr1(8'h02, 8'h10);
    cyc(1);
    i_sys_short <= 1'b1;
    cyc(5);
    check(o_irq_oe_n, 1'b1);
    wr1(8'h02, 8'h00);
    for (int e = 0; e < 4; e++)
    begin
      cyc(1);
      case (e)
        0: i_fast_charge_timeout <= 1'b1;
        1: i_temperature_zone <= 3'h2;
        2: i_charge_phase <= charger_pkg::PHASE_EOC;
        default: i_input_power_good <= 1'b0;
      endcase
      cyc(3);
      check(o_irq_oe_n, 1'b0);
      cyc(2550);
      check(o_irq_oe_n, 1'b0);
      cyc(20);
      check(o_irq_oe_n, 1'b1);
    end
    wr1(8'h06, 8'h6B);
    for (int k = 0; k < 4; k++)
    begin
      cyc(100);
      wr1(8'h06, 8'hEB);
    end
    check(o_power_off, 1'b0);
    cyc(WDOG_CYC + 20);
    check(o_power_off, 1'b1);
    for (int i = 0; i < PDOWN_CYC && o_power_off; i++)
      cyc(1);
    rd_n(8'h00, 1);
    check(rbuf[0], stat0(1'b1));
    rd_n(8'h06, 1);
    check(rbuf[0], charger_pkg::RST_WDC);
    wr1(8'h06, 8'h6B);
    cyc(100);
    wr1(8'h06, charger_pkg::RST_WDC);
    cyc(WDOG_CYC + 50);
    check(o_power_off, 1'b0);
    wr1(8'h03, 8'h3D);
    cyc(2);
    check(o_power_off, 1'b1);
    cyc(PDOWN_CYC - 30);
    check(o_power_off, 1'b1);
    cyc(40);
    check(o_power_off, 1'b0);
    check(o_power_path_control, charger_pkg::RST_PPC);
    i_one_wire_mode <= charger_pkg::MODE_PDOWN;
    i_one_wire_mode_wr <= 1'b1;
    cyc(1);
    i_one_wire_mode_wr <= 1'b0;
    cyc(3);
    check(o_power_off, 1'b1);
    cyc(PDOWN_CYC + 10);
    wr1(8'h03, 8'h3E);
    wr1(8'h03, 8'h3F);
    cyc(2);
    check(o_ship_mode, 1'b0);
    check(o_power_off, 1'b1);
    cyc(SHIP_CYC + 10);
    check(o_ship_mode, 1'b1);
    check(o_power_path_control, charger_pkg::RST_PPC);
    i_input_power_good <= 1'b1;
    cyc(4);
    check(o_ship_mode, 1'b0);
    wr1(8'h04, 8'h11);
    cyc(1);
    i_over_temp <= 1'b1;
    cyc(4);
    check(o_power_off, 1'b1);
    i_over_temp <= 1'b0;
    cyc(4);
    check(o_power_off, 1'b0);
    check(o_charge_voltage_term_control, charger_pkg::RST_CVT);
    wr1(8'h03, 8'h3C);
    cyc(1);
    i_input_power_good <= 1'b0;
    cyc(4);
    check(o_standby, 1'b1);
    i_one_wire_active <= 1'b1;
    cyc(2);
    check(o_standby, 1'b0);
    i_one_wire_active <= 1'b0;
    i_battery_por <= 1'b1;
    cyc(2);
    check(o_standby, 1'b0);
    complete_run();
  end
endmodule
bind charger_i2c_regs charger_i2c_regs_checker #(.SHIP_CYC(SHIP_CYC), .PDOWN_CYC(PDOWN_CYC),
  .WDOG_CYC(WDOG_CYC)) u_chk (.i_mclk, .i_sys_rst, .i_input_power_good, .i_over_temp,
  .i_battery_por, .i_one_wire_active, .o_scl_o, .o_sda_o, .o_irq_o, .o_scl_oe_n, .o_irq_oe_n,
  .o_power_path_control, .o_charge_voltage_term_control, .o_charge_enable_current_control,
  .o_watchdog_monitor_control, .o_power_off, .o_ship_mode, .o_standby);
